// >>> include/uart_fifo_regs.vh
// Field layout, thresholds and sizes of the UART FIFO control register.
// Assumes the includer provides clk_sys_i as the only clock.
`ifndef UART_FIFO_REGS_VH
`define UART_FIFO_REGS_VH

`define FCTL_RXTRIG_HI 7
`define FCTL_RXTRIG_LO 6
`define FCTL_TXTRIG_HI 5
`define FCTL_TXTRIG_LO 4
`define FCTL_TXCLR_BIT 2
`define FCTL_RXCLR_BIT 1
`define FCTL_EN_BIT 0
`define FCTL_RESET 8'h00

`define FIFO_DEPTH 64
`define FIFO_AW 6
`define FIFO_CW 7
// Fill capacity with the FIFOs enabled, and the single entry left when disabled
`define FIFO_CAP_ON 7'h40
`define FIFO_CAP_OFF 7'h01

`define TRIG_8 7'h08
`define TRIG_16 7'h10
`define TRIG_32 7'h20
`define TRIG_56 7'h38
`define TRIG_60 7'h3C

// Crystal clock edges a FIFO clear needs before it completes
`define CLR_XTAL_EDGES 2'h2

`endif

// >>> test/testbench.sv
// Self-checking bench for the UART FIFO control block.
// Assumes the design and the crystal source model are compiled first.
`timescale 1ns/1ns
module testbench;
   reg clk_sys_i, sys_rst_i, xtal_run, fctl_wr_i, enhanced_function_enable_i;
   reg tx_wr_i, tx_rd_i, rx_wr_i, rx_rd_i;
   reg [7:0] fctl_wdata_i, tx_wdata_i, rx_wdata_i;
   wire xtal_clk_i, tx_ready_o, tx_valid_o, rx_valid_o, fifo_en_o;
   wire tx_clr_busy_o, rx_clr_busy_o, rx_trig_o, tx_trig_o;
   wire [7:0] tx_rdata_o, rx_rdata_o;
   wire [6:0] rx_count_o, tx_count_o;
   integer fails, samples_checked, cyc, i, k, transmit_holding;
   xtal_source xtal_u (.run_i(xtal_run), .clk_o(xtal_clk_i));
   uart_fifo_control dut_u (.clk_sys_i, .sys_rst_i, .xtal_clk_i, .fctl_wr_i, .fctl_wdata_i,
      .enhanced_function_enable_i, .tx_wr_i, .tx_wdata_i, .tx_ready_o, .tx_valid_o,
      .tx_rdata_o, .tx_rd_i, .rx_wr_i, .rx_wdata_i, .rx_valid_o, .rx_rdata_o, .rx_rd_i,
      .fifo_en_o, .tx_clr_busy_o, .rx_clr_busy_o, .rx_trig_o, .tx_trig_o, .rx_count_o,
      .tx_count_o);
   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   task chk(input [63:0] n, input [7:0] e, input [7:0] s);
      begin
         samples_checked = samples_checked + 1;
         if (e !== s) begin
            fails = fails + 1;
            $display("[ERR] %0s exp %h got %h", n, e, s);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d fails %0d", samples_checked, fails);
         if (fails == 0 && samples_checked > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   always @(posedge clk_sys_i) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         fails = fails + 1;
         print_verdict;
      end
   end
   task wf(input [7:0] d);
      begin
         fctl_wdata_i = d;
         fctl_wr_i = 1'b1;
         @(negedge clk_sys_i);
         fctl_wr_i = 1'b0;
      end
   endtask
   // Runs the crystal until the clear ends, then keeps the host idle two periods
   task settle;
      begin
         xtal_run = 1'b1;
         @(negedge clk_sys_i);
         for (i = 0; i < 60 && (tx_clr_busy_o | rx_clr_busy_o) !== 1'b0; i = i + 1)
            @(negedge clk_sys_i);
         chk("busy", 8'h00, {tx_clr_busy_o, rx_clr_busy_o});
         repeat (8) @(negedge clk_sys_i);
         xtal_run = 1'b0;
      end
   endtask
   task push(input tx, input integer n);
      begin
         for (i = 0; i < n; i = i + 1) begin
            rx_wdata_i = i[7:0] + 8'hA0;
            tx_wdata_i = rx_wdata_i;
            tx_wr_i = tx;
            rx_wr_i = !tx;
            @(negedge clk_sys_i);
         end
         tx_wr_i = 1'b0;
         rx_wr_i = 1'b0;
      end
   endtask
   initial begin
      {xtal_run, fctl_wr_i, enhanced_function_enable_i, tx_wr_i, tx_rd_i} = 5'h00;
      {rx_wr_i, rx_rd_i, fctl_wdata_i, tx_wdata_i, rx_wdata_i} = 26'h0000000;
      fails = 0;
      samples_checked = 0;
      cyc = 0;
      sys_rst_i = 1'b1;
      repeat (10) @(negedge clk_sys_i);
      sys_rst_i = 1'b0;
      @(negedge clk_sys_i);
      chk("en", 8'h00, fifo_en_o);
      push(1'b0, 2);
      chk("rxcnt", 8'h01, rx_count_o);
      chk("rxvld", 8'h01, rx_valid_o);
      rx_rd_i = 1'b1;
      @(negedge clk_sys_i);
      rx_rd_i = 1'b0;
      chk("rxdat", 8'hA0, rx_rdata_o);
      chk("rxvld", 8'h00, rx_valid_o);
      wf(8'h03);
      repeat (20) @(negedge clk_sys_i);
      chk("rxbusy", 8'h01, rx_clr_busy_o);
      settle;
      chk("en", 8'h01, fifo_en_o);
      for (k = 0; k < 4; k = k + 1) begin
         wf({k[1:0], 6'h03});
         settle;
         chk("rxcnt", 8'h00, rx_count_o);
         transmit_holding = k == 0 ? 8 : k == 1 ? 16 : k == 2 ? 56 : 60;
         push(1'b0, transmit_holding - 1);
         repeat (2) @(negedge clk_sys_i);
         chk("rxtrig", 8'h00, rx_trig_o);
         push(1'b0, 1);
         repeat (2) @(negedge clk_sys_i);
         chk("rxtrig", 8'h01, rx_trig_o);
      end
      push(1'b0, 10);
      chk("rxcnt", 8'h40, rx_count_o);
      push(1'b1, 40);
      wf(8'h31);
      repeat (2) @(negedge clk_sys_i);
      chk("txtrig", 8'h01, tx_trig_o);
      enhanced_function_enable_i = 1'b1;
      for (k = 0; k < 4; k = k + 1) begin
         wf({2'b00, k[1:0], 4'h1});
         repeat (2) @(negedge clk_sys_i);
         chk("txtrig", (k < 2) ? 8'h01 : 8'h00, tx_trig_o);
      end
      chk("txvld", 8'h01, tx_valid_o);
      tx_rd_i = 1'b1;
      @(negedge clk_sys_i);
      tx_rd_i = 1'b0;
      chk("txdat", 8'hA0, tx_rdata_o);
      push(1'b1, 40);
      chk("txcnt", 8'h40, tx_count_o);
      chk("txrdy", 8'h00, tx_ready_o);
      wf(8'h05);
      chk("txvld", 8'h00, tx_valid_o);
      chk("rxvld", 8'h01, rx_valid_o);
      settle;
      chk("txcnt", 8'h00, tx_count_o);
      chk("rxcnt", 8'h40, rx_count_o);
      print_verdict;
   end
endmodule // testbench

// >>> test/uart_fifo_control_properties.sv
// Port-level checker for the UART FIFO control block.
// Assumes one system clock and an active-high asynchronous reset.
`timescale 1ns/1ns
module uart_fifo_checker (
   input wire clk_sys_i,
   input wire sys_rst_i,
   input wire xtal_clk_i,
   input wire fctl_wr_i,
   input wire [7:0] fctl_wdata_i,
   input wire enhanced_function_enable_i,
   input wire fifo_en_o,
   input wire tx_clr_busy_o,
   input wire rx_clr_busy_o,
   input wire rx_trig_o,
   input wire tx_trig_o,
   input wire [6:0] rx_count_o,
   input wire [6:0] tx_count_o
);
   reg [6:0] rthr_r;
   reg [6:0] tthr_r;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   always @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rthr_r <= 7'h08;
         tthr_r <= 7'h08;
      end else if (fctl_wr_i) begin
         rthr_r <= fctl_wdata_i[7] ? (fctl_wdata_i[6] ? 7'h3C : 7'h38) :
            (fctl_wdata_i[6] ? 7'h10 : 7'h08);
         if (enhanced_function_enable_i) begin
            tthr_r <= fctl_wdata_i[5] ? (fctl_wdata_i[4] ? 7'h38 : 7'h20) :
               (fctl_wdata_i[4] ? 7'h10 : 7'h08);
         end
      end
   end
   chk_en_follows_write: assert property (fctl_wr_i |=> fifo_en_o == $past(fctl_wdata_i[0]))
      else $error("fifo enable wrong");
   chk_tx_clear_empties: assert property (fctl_wr_i && fctl_wdata_i[2] |=> tx_clr_busy_o ##1 tx_count_o == 7'h00)
      else $error("tx clear wrong");
   chk_rx_clear_empties: assert property (fctl_wr_i && fctl_wdata_i[1] |=> rx_clr_busy_o ##1 rx_count_o == 7'h00)
      else $error("rx clear wrong");
   chk_tx_clear_xtal: assert property ((!xtal_clk_i)[*8] ##0 tx_clr_busy_o |=> tx_clr_busy_o)
      else $error("tx clear ended without crystal");
   chk_rx_clear_xtal: assert property ((!xtal_clk_i)[*8] ##0 rx_clr_busy_o |=> rx_clr_busy_o)
      else $error("rx clear ended without crystal");
   chk_rx_capacity: assert property (rx_count_o <= (fifo_en_o ? 7'h40 : 7'h01))
      else $error("rx count over capacity");
   chk_rx_trig_level: assert property (rx_trig_o == ($past(rx_count_o) >= $past(rthr_r)))
      else $error("rx trigger wrong");
   chk_tx_trig_level: assert property (tx_trig_o ==
      (($past(fifo_en_o) ? 7'h40 : 7'h01) - $past(tx_count_o) >= $past(tthr_r)))
      else $error("tx trigger wrong");
endmodule // uart_fifo_checker
bind uart_fifo_control uart_fifo_checker chk_u (.*);

// >>> test/xtal_source.sv
// Crystal oscillator model at the far side of the FIFO clear logic.
// Assumes the bench starts it for clears; it idles low when stopped.
`timescale 1ns/1ns
module xtal_source (
   input wire run_i,
   output reg clk_o
);
   initial clk_o = 1'b0;
   // 400 ns period, exactly four periods of the 100 ns system clock
   always #200 clk_o = run_i ? ~clk_o : 1'b0;
endmodule // xtal_source

// >>> verilog/uart_fifo_control.v
// Transmit and receive FIFOs of one UART channel with their control register.
// Assumes a write strobe from the host bus decoder and a crystal clock
// sampled as an ordinary asynchronous input.
`timescale 1ns/1ns
`include "uart_fifo_regs.vh"

// Notes on behaviour
// [R1] The FIFO control register can only be written, never read back.
// [R2] Bits 7:6 pick the receive threshold of 8, 16, 56 or 60 characters.
// [R3] Bits 5:4 pick the transmit threshold of 8, 16, 32 or 56 free spaces.
// [R4] The transmit threshold field changes only while enhanced functions are enabled.
// [R5] Bit 2 empties the transmit FIFO without touching the transmit shift register, then clears.
// [R6] Bit 1 empties the receive FIFO without touching the receive shift register, then clears.
// [R7] Bit 0 enables both FIFOs; zero, the reset value, disables them.
// [R8] A FIFO clear completes only after two crystal clock edges.
// [R9] The host waits two crystal clock periods after a clear before touching the holding data.
// [R10] Each FIFO holds 64 bytes.
// [R11] With FIFOs disabled, received characters sit only in the first entry.
// [R12] Trigger outputs rise when receive count or transmit free space reach the threshold.
module uart_fifo_control (
   input wire clk_sys_i,
   input wire sys_rst_i,
   input wire xtal_clk_i,
   input wire fctl_wr_i,
   input wire [7:0] fctl_wdata_i,
   input wire enhanced_function_enable_i,
   input wire tx_wr_i,
   input wire [7:0] tx_wdata_i,
   output wire tx_ready_o,
   output wire tx_valid_o,
   output reg [7:0] tx_rdata_o,
   input wire tx_rd_i,
   input wire rx_wr_i,
   input wire [7:0] rx_wdata_i,
   output wire rx_valid_o,
   output reg [7:0] rx_rdata_o,
   input wire rx_rd_i,
   output wire fifo_en_o,
   output wire tx_clr_busy_o,
   output wire rx_clr_busy_o,
   output reg rx_trig_o,
   output reg tx_trig_o,
   output reg [6:0] rx_count_o,
   output reg [6:0] tx_count_o
);
   reg fifo_en_r;
   reg [1:0] rx_trig_sel_r;
   reg [1:0] tx_trig_sel_r;
   reg tx_clr_r;
   reg rx_clr_r;
   reg [1:0] tx_clr_cnt_r;
   reg [1:0] rx_clr_cnt_r;
   reg xtal_s1_r;
   reg xtal_s2_r;
   reg xtal_d_r;
   wire xtal_rise;
   reg [7:0] tx_mem [0:`FIFO_DEPTH-1];
   reg [7:0] rx_mem [0:`FIFO_DEPTH-1];
   reg [5:0] tx_wp_r;
   reg [5:0] tx_rp_r;
   reg [5:0] rx_wp_r;
   reg [5:0] rx_rp_r;
   reg [6:0] rx_thr;
   reg [6:0] tx_thr;
   wire [6:0] tx_cap;
   wire [6:0] rx_cap;
   wire tx_push;
   wire tx_pop;
   wire rx_push;
   wire rx_pop;

   // Crystal clock is foreign to clk_sys_i, so it is synchronised before edge detection
   always @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         xtal_s1_r <= 1'b0;
         xtal_s2_r <= 1'b0;
         xtal_d_r <= 1'b0;
      end else begin
         xtal_s1_r <= xtal_clk_i;
         xtal_s2_r <= xtal_s1_r;
         xtal_d_r <= xtal_s2_r;
      end
   end
   assign xtal_rise = xtal_s2_r & ~xtal_d_r;

   // Register has no read path at all
   always @(posedge clk_sys_i or posedge sys_rst_i) begin // R1
      if (sys_rst_i) begin
         fifo_en_r <= 1'b0;
         rx_trig_sel_r <= 2'h0;
         tx_trig_sel_r <= 2'h0;
      end else if (fctl_wr_i) begin
         fifo_en_r <= fctl_wdata_i[`FCTL_EN_BIT]; // R7
         rx_trig_sel_r <= fctl_wdata_i[`FCTL_RXTRIG_HI:`FCTL_RXTRIG_LO]; // R2
         if (enhanced_function_enable_i)
            tx_trig_sel_r <= fctl_wdata_i[`FCTL_TXTRIG_HI:`FCTL_TXTRIG_LO]; // R4
      end
   end

   // Clear bits stay set until two crystal edges have passed; a stopped crystal stalls them
   always @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tx_clr_r <= 1'b0;
         rx_clr_r <= 1'b0;
         tx_clr_cnt_r <= 2'h0;
         rx_clr_cnt_r <= 2'h0;
      end else begin
         if (fctl_wr_i && fctl_wdata_i[`FCTL_TXCLR_BIT]) begin // R5
            tx_clr_r <= 1'b1;
            tx_clr_cnt_r <= 2'h0;
         end else if (tx_clr_r && xtal_rise) begin
            if (tx_clr_cnt_r == `CLR_XTAL_EDGES - 2'h1)
               tx_clr_r <= 1'b0; // R8
            tx_clr_cnt_r <= tx_clr_cnt_r + 2'h1;
         end
         if (fctl_wr_i && fctl_wdata_i[`FCTL_RXCLR_BIT]) begin // R6
            rx_clr_r <= 1'b1;
            rx_clr_cnt_r <= 2'h0;
         end else if (rx_clr_r && xtal_rise) begin
            if (rx_clr_cnt_r == `CLR_XTAL_EDGES - 2'h1)
               rx_clr_r <= 1'b0; // R8
            rx_clr_cnt_r <= rx_clr_cnt_r + 2'h1;
         end
      end
   end
   assign tx_clr_busy_o = tx_clr_r;
   assign rx_clr_busy_o = rx_clr_r;
   assign fifo_en_o = fifo_en_r;

   // Disabled FIFOs hold a single entry, location zero
   assign tx_cap = fifo_en_r ? `FIFO_CAP_ON : `FIFO_CAP_OFF; // R10
   assign rx_cap = fifo_en_r ? `FIFO_CAP_ON : `FIFO_CAP_OFF; // R11
   assign tx_ready_o = ~tx_clr_r && (tx_count_o < tx_cap);
   assign tx_valid_o = ~tx_clr_r && (tx_count_o != 7'h00);
   assign rx_valid_o = ~rx_clr_r && (rx_count_o != 7'h00);
   assign tx_push = tx_wr_i & tx_ready_o;
   assign tx_pop = tx_rd_i & tx_valid_o;
   // Overflow on receive drops the character, as with a real line
   assign rx_push = rx_wr_i & ~rx_clr_r & (rx_count_o < rx_cap);
   assign rx_pop = rx_rd_i & rx_valid_o;

   always @(posedge clk_sys_i) begin
      if (tx_push)
         tx_mem[tx_wp_r] <= tx_wdata_i;
      if (rx_push)
         rx_mem[rx_wp_r] <= rx_wdata_i;
   end

   // Clearing only touches pointers and counts; the shift registers live outside
   always @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tx_wp_r <= 6'h00;
         tx_rp_r <= 6'h00;
         tx_count_o <= 7'h00;
         tx_rdata_o <= 8'h00;
      end else if (tx_clr_r) begin // R5
         tx_wp_r <= 6'h00;
         tx_rp_r <= 6'h00;
         tx_count_o <= 7'h00;
      end else begin
         if (tx_push)
            tx_wp_r <= fifo_en_r ? tx_wp_r + 6'h01 : 6'h00;
         if (tx_pop) begin
            tx_rdata_o <= tx_mem[tx_rp_r];
            tx_rp_r <= fifo_en_r ? tx_rp_r + 6'h01 : 6'h00;
         end
         if (tx_push && !tx_pop)
            tx_count_o <= tx_count_o + 7'h01;
         else if (tx_pop && !tx_push)
            tx_count_o <= tx_count_o - 7'h01;
      end
   end

   always @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_wp_r <= 6'h00;
         rx_rp_r <= 6'h00;
         rx_count_o <= 7'h00;
         rx_rdata_o <= 8'h00;
      end else if (rx_clr_r) begin // R6
         rx_wp_r <= 6'h00;
         rx_rp_r <= 6'h00;
         rx_count_o <= 7'h00;
      end else begin
         if (rx_push)
            rx_wp_r <= fifo_en_r ? rx_wp_r + 6'h01 : 6'h00; // R11
         if (rx_pop) begin
            rx_rdata_o <= rx_mem[rx_rp_r];
            rx_rp_r <= fifo_en_r ? rx_rp_r + 6'h01 : 6'h00;
         end
         if (rx_push && !rx_pop)
            rx_count_o <= rx_count_o + 7'h01;
         else if (rx_pop && !rx_push)
            rx_count_o <= rx_count_o - 7'h01;
      end
   end

   always @* begin
      case (rx_trig_sel_r) // R2
         2'h0: rx_thr = `TRIG_8;
         2'h1: rx_thr = `TRIG_16;
         2'h2: rx_thr = `TRIG_56;
         default: rx_thr = `TRIG_60;
      endcase
      case (tx_trig_sel_r) // R3
         2'h0: tx_thr = `TRIG_8;
         2'h1: tx_thr = `TRIG_16;
         2'h2: tx_thr = `TRIG_32;
         default: tx_thr = `TRIG_56;
      endcase
   end

   always @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_trig_o <= 1'b0;
         tx_trig_o <= 1'b0;
      end else begin
         rx_trig_o <= rx_count_o >= rx_thr; // R12
         tx_trig_o <= (tx_cap - tx_count_o) >= tx_thr; // R12
      end
   end
endmodule // uart_fifo_control
